// ===== verilog/tsc_conv_port.sv
// conversion sequencer and serial slave port of the temperature sensor
// assumes adc_code is settled on the core clock when a conversion ends,
// and that cs_n, sclk and sdi come from the host asynchronously
`timescale 1ns/100ps
module tsc_conv_port #(
  parameter int UPDATE_CYC = tsc_pkg::UPDATE_CYC
) (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               sys_rst,
  // serial pins from host
  input  wire tsc_pkg::tsc_pins_s pins,
  // serial data out, two signals of the pin
  output logic                    sdo,
  output logic                    sdo_oe,
  // analog converter side
  input  wire tsc_pkg::tsc_temp_t adc_code,
  output logic                    conv_active,
  // status
  output logic                    osc_run,
  output logic                    shutdown_mode,
  output tsc_pkg::tsc_temp_t      result_word
);

  typedef struct packed {
    tsc_pkg::tsc_seq_e           seq;
    logic [tsc_pkg::TMR_W-1:0]   tmr;
    logic [tsc_pkg::TMR_W-1:0]   conv_cnt;
    tsc_pkg::tsc_temp_t          pend;
    tsc_pkg::tsc_temp_t          result;
    logic                        shutdown;
    tsc_pkg::tsc_pins_s          prev;
    logic [tsc_pkg::FRAME_BITS-1:0] shift;
    logic [tsc_pkg::CNT_W-1:0]   falls;
    logic [tsc_pkg::CNT_W-1:0]   rises;
    logic                        pd_cap;
    logic                        sdo;
    logic                        sdo_oe;
  } tsc_top_s;

  localparam logic [tsc_pkg::TMR_W-1:0] PERIOD_LAST = tsc_pkg::TMR_W'(UPDATE_CYC - 1);
  localparam logic [tsc_pkg::TMR_W-1:0] CONV_LAST   = tsc_pkg::TMR_W'(tsc_pkg::CONV_CYC - 1);

  tsc_top_s           st_r;
  tsc_top_s           st_nxt;
  tsc_pkg::tsc_pins_s pin_s;
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  logic               fifo_out_ready;
  tsc_pkg::tsc_temp_t fifo_out_data;

  // pin synchronisers
  tsc_sync #(
    .W (tsc_pkg::SYNC_W)
  ) u_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .async_in (pins),
    .sync_out (pin_s)
  );

  // completed results queue toward the readout register
  tsc_fifo #(
    .W (tsc_pkg::TEMP_W),
    .D (tsc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_valid  (st_r.seq == tsc_pkg::SEQ_PUSH),
    .in_ready  (fifo_in_ready),
    .in_data   (st_r.pend),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // drain only while deselected so a frame sees a steady word
  assign fifo_out_ready = pin_s.cs_n; // R17

  logic cs_fall;
  logic cs_rise;
  logic sel_hold;
  logic sclk_fall;
  logic sclk_rise;
  logic restart;

  // select edges ungated; clock edges gated by a select that holds across both samples
  assign cs_fall   = st_r.prev.cs_n && !pin_s.cs_n;
  assign cs_rise   = !st_r.prev.cs_n && pin_s.cs_n;
  assign sel_hold  = !st_r.prev.cs_n && !pin_s.cs_n; // R12
  assign sclk_fall = sel_hold && st_r.prev.sclk && !pin_s.sclk;
  assign sclk_rise = sel_hold && !st_r.prev.sclk && pin_s.sclk;

  always_comb begin
    st_nxt      = st_r;
    restart     = 1'b0;
    st_nxt.prev = pin_s;

    // readout register follows newest completed result
    if (fifo_out_valid && fifo_out_ready) begin
      st_nxt.result = fifo_out_data; // R4 R6 R9
    end

    // frame start: capture the word, drive the pin
    if (cs_fall) begin
      st_nxt.shift  = {st_r.result, {tsc_pkg::PAD_W{1'b0}}}; // R17 R15
      st_nxt.falls  = '0;
      st_nxt.rises  = '0;
      st_nxt.pd_cap = 1'b0;
      st_nxt.sdo    = 1'b0;
      st_nxt.sdo_oe = 1'b1;
    end

    // falling edges present the next bit, msb first
    if (sclk_fall && (st_r.falls != tsc_pkg::FRAME_CNT)) begin
      st_nxt.sdo   = st_r.shift[tsc_pkg::FRAME_BITS-1]; // R11 R15
      st_nxt.shift = {st_r.shift[tsc_pkg::FRAME_BITS-2:0], 1'b0};
      st_nxt.falls = st_r.falls + tsc_pkg::CNT_ONE;
      if ((st_r.falls + tsc_pkg::CNT_ONE) == tsc_pkg::LOAD_FALL) begin
        st_nxt.shutdown = st_r.pd_cap; // R13 R5
        if (st_r.shutdown && !st_r.pd_cap) begin
          restart = 1'b1; // R8
        end
      end
    end

    // rising edges sample the host bits; only the third is kept
    if (sclk_rise && (st_r.rises != tsc_pkg::FRAME_CNT)) begin
      st_nxt.rises = st_r.rises + tsc_pkg::CNT_ONE; // R10
      if ((st_r.rises + tsc_pkg::CNT_ONE) == tsc_pkg::PD_RISE) begin
        st_nxt.pd_cap = pin_s.sdi; // R14
      end
    end

    // frame end: release pin, restart conversion unless shut down
    if (cs_rise) begin
      st_nxt.sdo_oe = 1'b0; // R16
      st_nxt.sdo    = 1'b0;
      if (!st_nxt.shutdown) begin
        restart = 1'b1; // R7
      end
    end

    // conversion sequencer on the internal time base
    case (st_r.seq)
      tsc_pkg::SEQ_OFF: begin
        if (restart && !st_nxt.shutdown) begin
          st_nxt.seq      = tsc_pkg::SEQ_CONV; // R8
          st_nxt.tmr      = '0;
          st_nxt.conv_cnt = '0;
        end
      end
      tsc_pkg::SEQ_SLEEP: begin
        st_nxt.tmr = st_r.tmr + tsc_pkg::TMR_ONE;
        if (restart || (st_r.tmr >= PERIOD_LAST)) begin
          st_nxt.seq      = tsc_pkg::SEQ_CONV; // R2 R1
          st_nxt.tmr      = '0;
          st_nxt.conv_cnt = '0;
        end
      end
      tsc_pkg::SEQ_CONV: begin
        st_nxt.tmr      = st_r.tmr + tsc_pkg::TMR_ONE;
        st_nxt.conv_cnt = st_r.conv_cnt + tsc_pkg::TMR_ONE;
        if (restart) begin
          st_nxt.tmr      = '0;
          st_nxt.conv_cnt = '0;
        end else if (st_r.conv_cnt == CONV_LAST) begin
          st_nxt.pend = adc_code; // R3
          st_nxt.seq  = tsc_pkg::SEQ_PUSH;
        end
      end
      tsc_pkg::SEQ_PUSH: begin
        st_nxt.tmr = st_r.tmr + tsc_pkg::TMR_ONE;
        if (fifo_in_ready) begin
          if (st_nxt.shutdown) begin
            st_nxt.seq = tsc_pkg::SEQ_OFF;
          end else if (restart) begin
            st_nxt.seq      = tsc_pkg::SEQ_CONV;
            st_nxt.tmr      = '0;
            st_nxt.conv_cnt = '0;
          end else begin
            st_nxt.seq = tsc_pkg::SEQ_SLEEP; // R3
          end
        end
      end
      default: begin
        st_nxt.seq = tsc_pkg::SEQ_OFF;
      end
    endcase

    // shutdown stops the time base and abandons a running conversion
    if (st_nxt.shutdown &&
        ((st_r.seq == tsc_pkg::SEQ_SLEEP) || (st_r.seq == tsc_pkg::SEQ_CONV))) begin
      st_nxt.seq = tsc_pkg::SEQ_OFF; // R5
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r          <= '0;
      st_r.seq      <= tsc_pkg::SEQ_CONV;
      st_r.prev     <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sdo           = st_r.sdo;
  assign sdo_oe        = st_r.sdo_oe;
  assign conv_active   = (st_r.seq == tsc_pkg::SEQ_CONV);
  assign osc_run       = (st_r.seq != tsc_pkg::SEQ_OFF);
  assign shutdown_mode = st_r.shutdown;
  assign result_word   = st_r.result;

endmodule // tsc_conv_port

// ===== common/tsc_pkg.sv
// constants, types and state encodings for the temperature sensor conversion port
// assumes a single 100 MHz core clock; serial pins arrive asynchronous to it
//
// Summary of operation
// R1: conversions paced internally; serial clock only for access
// R2: normal mode starts conversion every 400 us
// R3: conversion lasts 25 us, then converter sleeps
// R4: latest completed result always held for readout
// R5: shutdown stops oscillator and all new conversions
// R6: shutdown still returns last pre-shutdown result
// R7: end of each access restarts a conversion; the code skips the restart while shut down
// R8: leaving shutdown restarts oscillator and converts
// R9: early re-read returns the previous result word
// R10: control bits sampled on serial clock rising edges
// R11: result bits shifted out on falling edges
// R12: chip select high makes serial clock ignored
// R13: 16-clock frame; control loads on fifteenth fall
// R14: only third written bit matters: shutdown request
// R15: 10-bit two's complement result, msb first
// R16: last bit held until deselect, then released
// R17: result latched into shifter at frame start
package tsc_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_US     = 1000;
  localparam int UPDATE_US     = 400;
  localparam int CONV_US       = 25;
  localparam int UPDATE_CYC    = (UPDATE_US * NS_PER_US) / CLK_PERIOD_NS;
  localparam int CONV_CYC      = (CONV_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W         = 16;

  // data and frame layout
  localparam int TEMP_W        = 10;
  localparam int FRAME_BITS    = 16;
  localparam int CNT_W         = 5;
  localparam int PAD_W         = FRAME_BITS - TEMP_W;
  localparam logic [CNT_W-1:0] FRAME_CNT  = 5'h10;
  localparam logic [CNT_W-1:0] LOAD_FALL  = 5'h0f;
  localparam logic [CNT_W-1:0] PD_RISE    = 5'h03;
  localparam logic [CNT_W-1:0] CNT_ONE    = 5'h01;
  localparam logic [TMR_W-1:0] TMR_ONE    = 16'h0001;

  // buffering and synchronisation
  localparam int FIFO_DEPTH    = 16;
  localparam int SYNC_W        = 3;

  typedef logic [TEMP_W-1:0] tsc_temp_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdi;
  } tsc_pins_s;

  typedef enum logic [3:0] {
    SEQ_SLEEP = 4'h1,
    SEQ_CONV  = 4'h2,
    SEQ_PUSH  = 4'h4,
    SEQ_OFF   = 4'h8
  } tsc_seq_e;

endpackage

// ===== verilog/tsc_sync.sv
// two-stage synchroniser for a bundle of asynchronous pin levels
// assumes each bit is an independent level; no multi-bit coherence implied
`timescale 1ns/100ps
module tsc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  // pins in, synchronised out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tsc_sync_s;

  tsc_sync_s st_r;
  tsc_sync_s st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = async_in;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '1; // idle-high select and clock: no false edge after reset
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.s2;

endmodule // tsc_sync

// ===== verilog/tsc_fifo.sv
// flip-flop fifo with valid/ready on both sides
// assumes depth is a power of two
`timescale 1ns/100ps
module tsc_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0]         wp;
    logic [AW:0]         rp;
  } tsc_fifo_s;

  tsc_fifo_s st_r;
  tsc_fifo_s st_nxt;
  logic      full;
  logic      empty;

  assign empty     = (st_r.wp == st_r.rp);
  assign full      = (st_r.wp[AW] != st_r.rp[AW]) && (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = st_r.mem[st_r.rp[AW-1:0]];

  always_comb begin
    st_nxt = st_r;
    if (in_valid && !full) begin
      st_nxt.mem[st_r.wp[AW-1:0]] = in_data;
      st_nxt.wp = st_r.wp + {{AW{1'b0}}, 1'b1};
    end
    if (out_ready && !empty) begin
      st_nxt.rp = st_r.rp + {{AW{1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule // tsc_fifo

// ===== testbench/tsc_conv_port_checker.sv
// assertions on the conversion port, bound to its top module
// assumes serial pins change away from the core clock edge
`timescale 1ns/100ps
module tsc_conv_port_checker #(
  parameter int UPDATE_CYC = tsc_pkg::UPDATE_CYC
) (
  // clock and reset
  input wire logic               ref_clk,
  input wire logic               sys_rst,
  // watched ports
  input wire tsc_pkg::tsc_pins_s pins,
  input wire logic               sdo,
  input wire logic               sdo_oe,
  input wire tsc_pkg::tsc_temp_t adc_code,
  input wire logic               conv_active,
  input wire logic               osc_run,
  input wire logic               shutdown_mode,
  input wire tsc_pkg::tsc_temp_t result_word
);
  localparam int CONV = tsc_pkg::CONV_CYC;
  int hi_r;
  int lo_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // run lengths of converter awake and asleep
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hi_r <= 0;
      lo_r <= 0;
    end else begin
      hi_r <= conv_active ? hi_r + 1 : 0;
      lo_r <= (conv_active || !osc_run) ? 0 : lo_r + 1;
    end
  end
  property p_conv_len; $fell(conv_active) && osc_run |-> hi_r >= CONV - 1; endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion cut short");
  property p_period; lo_r <= UPDATE_CYC - CONV; endproperty
  a_period: assert property (p_period) else $error("periodic start missed");
  property p_shut_idle; shutdown_mode && $past(shutdown_mode) |-> !conv_active && !osc_run;
  endproperty
  a_shut_idle: assert property (p_shut_idle) else $error("active in shutdown");
  property p_wake; $fell(shutdown_mode) |-> ##[0:3] (conv_active && osc_run); endproperty
  a_wake: assert property (p_wake) else $error("no conversion on wake");
  property p_ctl_frame; $changed(shutdown_mode) |-> !$past(pins.cs_n, 2) && !$past(pins.cs_n, 4);
  endproperty
  a_ctl_frame: assert property (p_ctl_frame) else $error("control changed outside frame");
  property p_oe_on; $fell(pins.cs_n) |-> ##[2:5] sdo_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("output not driven on select");
  property p_oe_off; $rose(pins.cs_n) |-> ##[2:5] !sdo_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("output not released");
  property p_oe_idle; pins.cs_n [*6] |-> !sdo_oe && !sdo; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("output active while deselected");
  property p_shift_fall; pins.sclk [*3] ##0 (sdo_oe && $past(sdo_oe)) |-> $stable(sdo);
  endproperty
  a_shift_fall: assert property (p_shift_fall) else $error("data moved on rising clock");
  property p_result_hold; $changed(result_word) |-> $past(pins.cs_n, 2) || $past(pins.cs_n, 3);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result moved in frame");
endmodule // tsc_conv_port_checker

bind tsc_conv_port tsc_conv_port_checker #(.UPDATE_CYC(UPDATE_CYC)) tsc_conv_port_checker_inst (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .pins(pins), .sdo(sdo), .sdo_oe(sdo_oe),
  .adc_code(adc_code), .conv_active(conv_active), .osc_run(osc_run),
  .shutdown_mode(shutdown_mode), .result_word(result_word));

// ===== testbench/tsc_host_model.sv
// serial master model: selects, clocks frames at 160 ns per bit, writes control, reads data
// assumes pins are sampled by the device on its core clock
`timescale 1ns/100ps
module tsc_host_model (
  // core clock
  input  wire logic         ref_clk,
  // serial link
  output tsc_pkg::tsc_pins_s pins,
  input  wire logic         sdo,
  input  wire logic         sdo_oe
);
  logic last_r = 1'b0;
  wire  line = sdo_oe ? sdo : ~last_r;
  always @(posedge ref_clk) if (sdo_oe) last_r <= sdo;
  initial pins = '{cs_n: 1'b1, sclk: 1'b1, sdi: 1'b0};
  task automatic frame(input logic [15:0] ctl, input int n, output logic [15:0] rd);
    rd = '0;
    pins.cs_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    for (int i = 0; i < n; i++) begin
      pins.sclk = 1'b0;
      pins.sdi = ctl[15-i];
      repeat (8) @(negedge ref_clk);
      rd = {rd[14:0], line};
      pins.sclk = 1'b1;
      repeat (8) @(negedge ref_clk);
    end
    pins.cs_n = 1'b1;
    repeat (8) @(negedge ref_clk);
  endtask
endmodule // tsc_host_model

// ===== testbench/tsc_conv_port_test.sv
// self-checking bench for the conversion port, fifo reached via the top
// assumes the host model drives all serial pins
`timescale 1ns/100ps
module tsc_conv_port_test;
  localparam int UPD = 6000;
  logic               ref_clk, sys_rst, sdo, sdo_oe, conv_active, osc_run, shutdown_mode;
  tsc_pkg::tsc_pins_s pins;
  tsc_pkg::tsc_temp_t adc_code, result_word, ap;
  logic [15:0]        got, exp_q[$];
  logic [31:0]        seed;
  int                 errors, compares;
  event               got_ev;
  tsc_conv_port #(.UPDATE_CYC(UPD)) tsc_conv_port_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .pins(pins), .sdo(sdo), .sdo_oe(sdo_oe), .adc_code(adc_code), .conv_active(conv_active),
    .osc_run(osc_run), .shutdown_mode(shutdown_mode), .result_word(result_word));
  tsc_host_model tsc_host_model_inst (.ref_clk(ref_clk), .pins(pins), .sdo(sdo), .sdo_oe(sdo_oe));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want) begin
      errors++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic rd_frame(input logic pd, input int n, input logic [15:0] want);
    exp_q.push_back(want);
    tsc_host_model_inst.frame({seed[1:0], pd, 13'h0}, n, got);
    -> got_ev;
  endtask
  task automatic new_code;
    seed = xs(seed);
    adc_code = seed[9:0];
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    wt(100000);
    errors++;
    report_and_stop;
  end
  always @(got_ev) chk(got, exp_q.pop_front());
  initial begin
    {sys_rst, adc_code} = {1'b1, 10'h0};
    {seed, errors, compares} = {32'h350060dd, 64'h0};
    wt(20);
    sys_rst = 1'b0;
    new_code;
    ap = adc_code;
    wt(3);
    chk(16'(result_word), 16'h0);
    chk(16'(conv_active), 16'h1);
    chk(16'(osc_run), 16'h1);
    chk(16'(sdo_oe), 16'h0);
    chk(16'(shutdown_mode), 16'h0);
    wt(2600);
    rd_frame(1'b0, 16, {ap, 6'h0});
    new_code;
    rd_frame(1'b0, 16, {ap, 6'h0});
    chk(16'(conv_active), 16'h1);
    wt(2600);
    chk(16'(conv_active), 16'h0);
    ap = adc_code;
    rd_frame(1'b0, 16, {ap, 6'h0});
    wt(2700);
    new_code;
    ap = adc_code;
    wt(UPD);
    rd_frame(1'b0, 16, {ap, 6'h0});
    rd_frame(1'b1, 16, {ap, 6'h0});
    chk(16'(osc_run), 16'h0);
    new_code;
    wt(UPD + 2600);
    chk(16'(result_word), 16'(ap));
    rd_frame(1'b1, 16, {ap, 6'h0});
    rd_frame(1'b0, 10, {6'h0, ap});
    chk(16'(shutdown_mode), 16'h1);
    rd_frame(1'b0, 16, {ap, 6'h0});
    chk(16'(shutdown_mode), 16'h0);
    ap = adc_code;
    wt(2600);
    rd_frame(1'b0, 16, {ap, 6'h0});
    wt(2);
    report_and_stop;
  end
endmodule // tsc_conv_port_test
